// File: qudp_pkg.sv
package qudp_pkg;
  // sizes
  localparam int CNT_W = 32;
  localparam int BLK_N = 2;
  localparam int ADDR_W = 8;
  localparam int CTRL_W = 11;
  // register map, per block, stride between blocks
  localparam logic [7:0] BLK_STRIDE = 8'h20;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_CMD = 5'h04;
  localparam logic [4:0] REG_COUNT = 5'h08;
  localparam logic [4:0] REG_LATCH = 5'h0c;
  localparam logic [4:0] REG_HIGH = 5'h10;
  localparam logic [4:0] REG_LOW = 5'h14;
  localparam logic [4:0] REG_PERIOD = 5'h18;
  localparam logic [4:0] REG_STATUS = 5'h1c;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
  // control register fields
  localparam int B_MODE = 0;
  localparam int B_INVCLK = 1;
  localparam int B_INVDIR = 2;
  localparam int B_REFLATCH = 3;
  localparam int B_CLRREL = 4;
  localparam int B_LATREL = 5;
  localparam int B_REFONLY = 6;
  localparam int B_PWMSEL = 7;
  localparam int B_PWMEDGE = 9;
  localparam int B_PWMEN = 10;
  // command register fields
  localparam int C_SLATCH = 0;
  localparam int C_SCLEAR = 1;
  localparam int C_PWMCLR = 2;
  // counter input positions
  localparam int IN_A = 0;
  localparam int IN_B = 1;
  localparam int IN_REF = 2;
  // bus answers
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // timing: pwm reference against module clock
  localparam int CLK_HZ = 100_000_000;
  localparam int PWM_REF_HZ = 100_000_000;
  localparam logic [CNT_W-1:0] PWM_STEP = CNT_W'(PWM_REF_HZ / CLK_HZ);
  // read channel states
  typedef enum logic {RD_IDLE = 1'b0, RD_RESP = 1'b1} qudp_rd_t;
endpackage

// File: qudp_blk_if.sv
`timescale 1ns/100ps
interface qudp_blk_if;
  logic [qudp_pkg::CTRL_W-1:0] ctrl;
  logic softLatch;
  logic softClear;
  logic [qudp_pkg::CNT_W-1:0] count;
  logic [qudp_pkg::CNT_W-1:0] latchVal;
  logic [2:0] syncLvl;
  logic [2:0] prevLvl;
  modport top (output ctrl, softLatch, softClear, input count, latchVal, syncLvl, prevLvl);
  modport blk (input ctrl, softLatch, softClear, output count, latchVal, syncLvl, prevLvl);
endinterface

// File: qudp_ud_cnt.sv
`timescale 1ns/100ps
module qudp_ud_cnt (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // raw inputs: a or count pulse, b or sense, reference
  input wire logic [2:0] rawIn,
  // settings and results
  qudp_blk_if.blk bif
);
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic [2:0] prev_reg;
  logic [qudp_pkg::CNT_W-1:0] count_reg;
  logic [qudp_pkg::CNT_W-1:0] count_next;
  logic [qudp_pkg::CNT_W-1:0] latch_reg;
  logic quad;
  logic pulseFall;
  logic senseUp;
  logic aChg;
  logic bChg;
  logic quadUp;
  logic refRise;
  logic refClear;
  logic refLatch;

  // two-stage synchroniser, third stage for edges
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
      prev_reg <= 3'h0;
    end else begin
      meta_reg <= rawIn;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // edge and direction decode
  assign quad = bif.ctrl[qudp_pkg::B_MODE];
  assign pulseFall = (prev_reg[qudp_pkg::IN_A] ^ bif.ctrl[qudp_pkg::B_INVCLK])
    & ~(sync_reg[qudp_pkg::IN_A] ^ bif.ctrl[qudp_pkg::B_INVCLK]);
  assign senseUp = sync_reg[qudp_pkg::IN_B] ^ bif.ctrl[qudp_pkg::B_INVDIR];
  assign aChg = sync_reg[qudp_pkg::IN_A] ^ prev_reg[qudp_pkg::IN_A];
  assign bChg = sync_reg[qudp_pkg::IN_B] ^ prev_reg[qudp_pkg::IN_B];
  assign quadUp = sync_reg[qudp_pkg::IN_A] ^ prev_reg[qudp_pkg::IN_B];
  assign refRise = sync_reg[qudp_pkg::IN_REF] & ~prev_reg[qudp_pkg::IN_REF];

  // reference action: clear or latch, each only when released
  assign refClear = bif.ctrl[qudp_pkg::B_CLRREL] & ~bif.ctrl[qudp_pkg::B_REFLATCH]
    & ((quad & ~bif.ctrl[qudp_pkg::B_REFONLY]) ? (&sync_reg) : refRise);
  assign refLatch = bif.ctrl[qudp_pkg::B_LATREL] & bif.ctrl[qudp_pkg::B_REFLATCH] & refRise;

  // next count; clearing wins over a count step
  always_comb begin
    count_next = count_reg;
    if (quad) begin
      if (aChg ^ bChg) begin
        count_next = quadUp ? count_reg + 32'h1 : count_reg - 32'h1;
      end
    end else if (pulseFall) begin
      count_next = senseUp ? count_reg + 32'h1 : count_reg - 32'h1;
    end
    if (refClear | bif.softClear) begin
      count_next = '0;
    end
  end

  // count and latch storage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= '0;
      latch_reg <= '0;
    end else begin
      count_reg <= count_next;
      if (bif.softLatch | refLatch) begin
        latch_reg <= count_reg;
      end
    end
  end

  assign bif.count = count_reg;
  assign bif.latchVal = latch_reg;
  assign bif.syncLvl = sync_reg;
  assign bif.prevLvl = prev_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  latch_copy_a: assert property (bif.softLatch |=> latch_reg == $past(count_reg))
    else $error("latch missed count");
  ref_clear_a: assert property (refClear && !refLatch |=> count_reg == '0)
    else $error("reference clear missed");
  pulse_step_a: assert property (!quad && pulseFall && senseUp && !refClear && !bif.softClear
    |=> count_reg == $past(count_reg) + 32'h1)
    else $error("pulse did not count up");
  quad_both_a: assert property (quad && aChg && bChg && !refClear && !bif.softClear
    |=> $stable(count_reg))
    else $error("quadrature counted on double change");
endmodule

// File: qudp_top.sv
`timescale 1ns/100ps
// Function
// - two independent counter blocks, each set up by software
// - each block has a 32-bit up/down counter and a 32-bit pulse-width counter
// - both counters of a block run together without disturbing each other
// - up/down counter selects pulse-plus-sense or four-edge quadrature mode
// - pulse mode: each falling pulse edge steps the counter by one
// - pulse mode: sense high counts up, sense low counts down
// - software inverts pulse and sense inputs independently
// - software command copies the count into the latch register
// - a setting picks whether the reference clears or latches
// - reference action works only after its release setting is on
// - rising reference edge performs the chosen latch, or the clear in pulse mode and in reference-only quadrature
// - quadrature: every edge of both phases counts, four per period
// - quadrature clear needs both phases and reference high, or reference alone
// - pulse-width counter analyses a chosen input on a chosen edge
// - high time, low time, period and a new-result flag readable by software
// - high and low times counted at one hundred megahertz
// - second block inputs double as first three isolated inputs
// - first block reference doubles as sync serial data input
module qudp_top (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // axi4-lite write address
  input wire logic [qudp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [qudp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // first block encoder inputs
  input wire logic encA,
  input wire logic encB,
  // reference of first block, shared with serial data
  input wire logic syncSerialData,
  // isolated inputs 0..2, shared with second block
  input wire logic [2:0] isolatedIn,
  // synchronised levels for the other users of shared pins
  output logic serialDataLvl,
  output logic [2:0] isolatedLvl
);
  localparam int N = qudp_pkg::BLK_N;

  logic awHave_reg;
  logic wHave_reg;
  logic [qudp_pkg::ADDR_W-1:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  qudp_pkg::qudp_rd_t rd_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wrFire;
  logic [2:0] wrBlk;
  logic [4:0] wrOff;
  logic wrHit;
  logic [2:0] rdBlk;
  logic [4:0] rdOff;
  logic [31:0] rdMux;
  logic rdHit;
  logic [qudp_pkg::CTRL_W-1:0] ctrl_reg [N];
  logic [N-1:0] sLatch_reg;
  logic [N-1:0] sClear_reg;
  logic [N-1:0] pwmClr;
  logic [31:0] cntArr [N];
  logic [31:0] latArr [N];
  logic [31:0] highCnt_reg [N];
  logic [31:0] lowCnt_reg [N];
  logic [31:0] high_reg [N];
  logic [31:0] low_reg [N];
  logic [31:0] period_reg [N];
  logic [N-1:0] pwmValid_reg;
  logic [N-1:0] pwmCur;
  logic [N-1:0] pwmTrig;
  logic [2:0] rawIn [N];

  qudp_blk_if bif [N] ();

  // pin sharing: pins feed counters and their other users at once
  assign rawIn[0] = {syncSerialData, encB, encA};
  assign rawIn[1] = isolatedIn;
  assign serialDataLvl = bif[0].syncLvl[qudp_pkg::IN_REF];
  assign isolatedLvl = bif[1].syncLvl;

  // address decode
  assign wrBlk = awAddr_reg[7:5];
  assign wrOff = awAddr_reg[4:0];
  assign wrHit = (32'(wrBlk) < N);
  assign rdBlk = s_axi_araddr[7:5];
  assign rdOff = s_axi_araddr[4:0];
  assign rdHit = (32'(rdBlk) < N);
  assign wrFire = awHave_reg & wHave_reg & ~bvalid_reg;

  // write channels accepted in either order
  assign s_axi_awready = ~awHave_reg & ~bvalid_reg;
  assign s_axi_wready = ~wHave_reg & ~bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // write address and data holding
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      awAddr_reg <= '0;
      wData_reg <= 32'h0;
      wStrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        awHave_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end else if (wrFire) begin
        awHave_reg <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHave_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end else if (wrFire) begin
        wHave_reg <= 1'b0;
      end
    end
  end

  // write response, unmapped block gives slverr
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= qudp_pkg::RESP_OK;
    end else if (wrFire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wrHit ? qudp_pkg::RESP_OK : qudp_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // read mux
  always_comb begin
    rdMux = 32'h0;
    if (!rdHit) begin
      rdMux = 32'h0;
    end else if (rdOff == qudp_pkg::REG_CTRL) begin
      rdMux = 32'(ctrl_reg[rdBlk[0]]);
    end else if (rdOff == qudp_pkg::REG_COUNT) begin
      rdMux = cntArr[rdBlk[0]];
    end else if (rdOff == qudp_pkg::REG_LATCH) begin
      rdMux = latArr[rdBlk[0]];
    end else if (rdOff == qudp_pkg::REG_HIGH) begin
      rdMux = high_reg[rdBlk[0]];
    end else if (rdOff == qudp_pkg::REG_LOW) begin
      rdMux = low_reg[rdBlk[0]];
    end else if (rdOff == qudp_pkg::REG_PERIOD) begin
      rdMux = period_reg[rdBlk[0]];
    end else if (rdOff == qudp_pkg::REG_STATUS) begin
      rdMux = 32'(pwmValid_reg[rdBlk[0]]);
    end
  end

  // read channel, one answer per address
  assign s_axi_arready = (rd_reg == qudp_pkg::RD_IDLE);
  assign s_axi_rvalid = (rd_reg == qudp_pkg::RD_RESP);
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_reg <= qudp_pkg::RD_IDLE;
      rdata_reg <= 32'h0;
      rresp_reg <= qudp_pkg::RESP_OK;
    end else begin
      case (rd_reg)
        qudp_pkg::RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_reg <= qudp_pkg::RD_RESP;
            rdata_reg <= rdMux;
            rresp_reg <= rdHit ? qudp_pkg::RESP_OK : qudp_pkg::RESP_SLVERR;
          end
        end
        default: begin
          if (s_axi_rready) begin
            rd_reg <= qudp_pkg::RD_IDLE;
          end
        end
      endcase
    end
  end

  // per block: settings, commands, counter core and pulse-width counter
  for (genvar g = 0; g < N; g++) begin : g_blk
    logic ctrlSel;
    logic cmdSel;
    assign ctrlSel = wrFire & wrHit & (wrBlk == 3'(g)) & (wrOff == qudp_pkg::REG_CTRL);
    assign cmdSel = wrFire & wrHit & (wrBlk == 3'(g)) & (wrOff == qudp_pkg::REG_CMD) & wStrb_reg[0];
    assign pwmClr[g] = cmdSel & wData_reg[qudp_pkg::C_PWMCLR];

    // settings register, byte lanes honoured
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        ctrl_reg[g] <= qudp_pkg::CTRL_RST;
      end else if (ctrlSel) begin
        if (wStrb_reg[0]) begin
          ctrl_reg[g][7:0] <= wData_reg[7:0];
        end
        if (wStrb_reg[1]) begin
          ctrl_reg[g][qudp_pkg::CTRL_W-1:8] <= wData_reg[qudp_pkg::CTRL_W-1:8];
        end
      end
    end

    // one-cycle command pulses
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        sLatch_reg[g] <= 1'b0;
        sClear_reg[g] <= 1'b0;
      end else begin
        sLatch_reg[g] <= cmdSel & wData_reg[qudp_pkg::C_SLATCH];
        sClear_reg[g] <= cmdSel & wData_reg[qudp_pkg::C_SCLEAR];
      end
    end

    assign bif[g].ctrl = ctrl_reg[g];
    assign bif[g].softLatch = sLatch_reg[g];
    assign bif[g].softClear = sClear_reg[g];
    assign cntArr[g] = bif[g].count;
    assign latArr[g] = bif[g].latchVal;

    qudp_ud_cnt u_cnt (
      .clk(clk),
      .sys_rst(sys_rst),
      .rawIn(rawIn[g]),
      .bif(bif[g])
    );

    // pulse-width input and edge choice; select 3 falls back to reference
    logic [1:0] sel;
    logic cur;
    logic prv;
    assign sel = ctrl_reg[g][qudp_pkg::B_PWMSEL+1:qudp_pkg::B_PWMSEL];
    assign cur = (sel == 2'h0) ? bif[g].syncLvl[qudp_pkg::IN_A] :
      (sel == 2'h1) ? bif[g].syncLvl[qudp_pkg::IN_B] : bif[g].syncLvl[qudp_pkg::IN_REF];
    assign prv = (sel == 2'h0) ? bif[g].prevLvl[qudp_pkg::IN_A] :
      (sel == 2'h1) ? bif[g].prevLvl[qudp_pkg::IN_B] : bif[g].prevLvl[qudp_pkg::IN_REF];
    assign pwmCur[g] = cur;
    assign pwmTrig[g] = ctrl_reg[g][qudp_pkg::B_PWMEN]
      & (ctrl_reg[g][qudp_pkg::B_PWMEDGE] ? (prv & ~cur) : (~prv & cur));

    // high and low time counting, separate from the up/down counter
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        highCnt_reg[g] <= 32'h0;
        lowCnt_reg[g] <= 32'h0;
      end else if (!ctrl_reg[g][qudp_pkg::B_PWMEN]) begin
        highCnt_reg[g] <= 32'h0;
        lowCnt_reg[g] <= 32'h0;
      end else if (pwmTrig[g]) begin
        highCnt_reg[g] <= cur ? qudp_pkg::PWM_STEP : 32'h0;
        lowCnt_reg[g] <= cur ? 32'h0 : qudp_pkg::PWM_STEP;
      end else if (cur) begin
        highCnt_reg[g] <= highCnt_reg[g] + qudp_pkg::PWM_STEP;
      end else begin
        lowCnt_reg[g] <= lowCnt_reg[g] + qudp_pkg::PWM_STEP;
      end
    end

    // results of the last whole period
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        high_reg[g] <= 32'h0;
        low_reg[g] <= 32'h0;
        period_reg[g] <= 32'h0;
      end else if (pwmTrig[g]) begin
        high_reg[g] <= highCnt_reg[g];
        low_reg[g] <= lowCnt_reg[g];
        period_reg[g] <= highCnt_reg[g] + lowCnt_reg[g];
      end
    end

    // new-result flag, set wins over clear
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        pwmValid_reg[g] <= 1'b0;
      end else if (pwmTrig[g]) begin
        pwmValid_reg[g] <= 1'b1;
      end else if (pwmClr[g]) begin
        pwmValid_reg[g] <= 1'b0;
      end
    end

    pwm_period_a: assert property (@(posedge clk) disable iff (sys_rst)
      pwmTrig[g] |=> period_reg[g] == high_reg[g] + low_reg[g])
      else $error("period not high plus low");
    valid_set_a: assert property (@(posedge clk) disable iff (sys_rst)
      pwmTrig[g] && pwmClr[g] |=> pwmValid_reg[g])
      else $error("result flag clear beat set");
    high_run_a: assert property (@(posedge clk) disable iff (sys_rst)
      ctrl_reg[g][qudp_pkg::B_PWMEN] && cur && !pwmTrig[g] ##1 ctrl_reg[g][qudp_pkg::B_PWMEN]
      |-> highCnt_reg[g] == $past(highCnt_reg[g]) + qudp_pkg::PWM_STEP)
      else $error("high time did not advance");
  end

  b_answer_a: assert property (@(posedge clk) disable iff (sys_rst)
    wrFire |=> s_axi_bvalid ##0 (s_axi_bvalid throughout (!s_axi_bready [*1]))
    or (s_axi_bvalid && s_axi_bready))
    else $error("write answer missing");
  r_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule

// File: qudp_enc_src.sv
`timescale 1ns/100ps
module qudp_enc_src (
  // clock
  input wire logic clk,
  // a or pulse, b or sense, reference
  output logic [2:0] pins
);
  // cycles each level stands, keeps the source under its rate limits
  localparam int HOLD = 4;
  logic [1:0] ph;
  // all lines low at start
  initial begin
    pins = 3'h0;
    ph = 2'h0;
  end
  // set one line just after a rising edge, then hold it
  task automatic drive(input int i, input logic v, input int c);
    @(posedge clk);
    pins[i] <= v;
    repeat (c - 1) @(posedge clk);
  endtask
  // one pulse away from idle and back
  task automatic pulse(input int i, input logic idle);
    drive(i, ~idle, HOLD);
    drive(i, idle, HOLD);
  endtask
  // one quadrature step, a leads b when counting up
  task automatic qStep(input logic up);
    ph = up ? ph + 2'h1 : ph - 2'h1;
    @(posedge clk);
    pins[1:0] <= {ph[1], ph[1] ^ ph[0]};
    repeat (HOLD - 1) @(posedge clk);
  endtask
  // both phases change at one edge, which must not count
  task automatic jump();
    ph = ph + 2'h2;
    @(posedge clk);
    pins[1:0] <= {ph[1], ph[1] ^ ph[0]};
    repeat (HOLD - 1) @(posedge clk);
  endtask
  // square wave, high and low times in cycles
  task automatic square(input int i, input int hi, input int lo, input int n);
    repeat (n) begin
      drive(i, 1'b1, hi);
      drive(i, 1'b0, lo);
    end
  endtask
endmodule

// File: test_qudp_top.sv
`timescale 1ns/100ps
module test_qudp_top;
  // offsets within a block, second block base
  localparam logic [7:0] B1 = qudp_pkg::BLK_STRIDE;
  localparam logic [7:0] A_CTL = 8'(qudp_pkg::REG_CTRL);
  localparam logic [7:0] A_CMD = 8'(qudp_pkg::REG_CMD);
  localparam logic [7:0] A_CNT = 8'(qudp_pkg::REG_COUNT);
  localparam logic [7:0] A_LAT = 8'(qudp_pkg::REG_LATCH);
  localparam logic [7:0] A_HI = 8'(qudp_pkg::REG_HIGH);
  localparam logic [7:0] A_LO = 8'(qudp_pkg::REG_LOW);
  localparam logic [7:0] A_PER = 8'(qudp_pkg::REG_PERIOD);
  localparam logic [7:0] A_ST = 8'(qudp_pkg::REG_STATUS);
  // clock, reset, bus and pins
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
  logic [31:0] wData = 32'h0;
  logic [3:0] wStrb = 4'h0;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid, serLvl;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  logic [2:0] isoLvl, pin0, pin1;
  int n_fail = 0;
  int samples_checked = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  // device under test
  qudp_top dut_u (
    .clk(clk), .sys_rst(sysRst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .encA(pin0[0]), .encB(pin0[1]), .syncSerialData(pin0[2]), .isolatedIn(pin1),
    .serialDataLvl(serLvl), .isolatedLvl(isoLvl)
  );
  // one source per counter block
  qudp_enc_src src0 (.clk(clk), .pins(pin0));
  qudp_enc_src src1 (.clk(clk), .pins(pin1));
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  // counts, verdict, end of run
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // a bus answer that never came
  task automatic timedOut();
    n_fail++;
    $display("ERROR at %0t: no bus answer", $time);
    tally_and_finish();
  endtask
  // write: address and data offered together, each released when taken
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    logic ha, hw, hb;
    n = 0;
    hb = 1'b0;
    @(posedge clk);
    awAddr <= a;
    awValid <= 1'b1;
    wData <= d;
    wStrb <= s;
    wValid <= 1'b1;
    bReady <= 1'b1;
    while (!hb) begin
      @(negedge clk);
      ha = awValid & awReady;
      hw = wValid & wReady;
      hb = bValid & bReady;
      if (hb) check({30'h0, bResp}, {30'h0, er});
      @(posedge clk);
      if (ha) awValid <= 1'b0;
      if (hw) wValid <= 1'b0;
      if (hb) bReady <= 1'b0;
      n++;
      if (n > 50) timedOut();
    end
  endtask
  // read with expected data and answer, spaced after input activity
  task automatic axiRead(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    logic ha, hr;
    n = 0;
    hr = 1'b0;
    repeat (2) @(posedge clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    while (!hr) begin
      @(negedge clk);
      ha = arValid & arReady;
      hr = rValid & rReady;
      if (hr) check(rData, exp);
      if (hr) check({30'h0, rResp}, {30'h0, er});
      @(posedge clk);
      if (ha) arValid <= 1'b0;
      if (hr) rReady <= 1'b0;
      n++;
      if (n > 50) timedOut();
    end
  endtask
  // full-word write and plain read
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axiWrite(a, d, 4'hf, qudp_pkg::RESP_OK);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    axiRead(a, exp, qudp_pkg::RESP_OK);
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    sysRst <= 1'b0;
    // all registers of both blocks start at zero, command reads zero
    for (int i = 0; i < 16; i++) rd(8'(i * 4), 32'h0);
    axiWrite(8'h40, 32'h1, 4'hf, qudp_pkg::RESP_SLVERR);
    axiRead(8'hfc, 32'h0, qudp_pkg::RESP_SLVERR);
    // control bytes obey strobes, counts ignore writes
    axiWrite(B1 + A_CTL, 32'h7ff, 4'h2, qudp_pkg::RESP_OK);
    rd(B1 + A_CTL, 32'h700);
    wr(B1 + A_CNT, 32'h1234);
    rd(B1 + A_CNT, 32'h0);
    // pulse mode: five up, two down
    src0.drive(1, 1'b1, 4);
    repeat (5) src0.pulse(0, 1'b0);
    src0.drive(1, 1'b0, 4);
    repeat (2) src0.pulse(0, 1'b0);
    rd(A_CNT, 32'h3);
    // both inputs inverted: raw rise counts, raw low sense counts up
    wr(A_CTL, 32'h6);
    repeat (2) src0.pulse(0, 1'b0);
    rd(A_CNT, 32'h5);
    // software latch, then software clear
    wr(A_CMD, 32'h1);
    rd(A_LAT, 32'h5);
    wr(A_CMD, 32'h2);
    rd(A_CNT, 32'h0);
    // count down through zero
    src0.drive(1, 1'b1, 4);
    repeat (3) src0.pulse(0, 1'b0);
    rd(A_CNT, 32'hfffffffd);
    // reference without release does nothing, with release clears
    src0.pulse(2, 1'b0);
    rd(A_CNT, 32'hfffffffd);
    wr(A_CTL, 32'h16);
    src0.pulse(2, 1'b0);
    rd(A_CNT, 32'h0);
    src0.drive(1, 1'b0, 4);
    repeat (4) src0.pulse(0, 1'b0);
    // latch mode with only clear released: no action
    wr(A_CTL, 32'h1e);
    src0.pulse(2, 1'b0);
    rd(A_CNT, 32'h4);
    rd(A_LAT, 32'h5);
    wr(A_CTL, 32'h2e);
    src0.pulse(2, 1'b0);
    rd(A_LAT, 32'h4);
    // shared reference pin also reaches the serial data user
    src0.drive(2, 1'b1, 4);
    check({31'h0, serLvl}, 32'h1);
    src0.drive(2, 1'b0, 4);
    rd(B1 + A_CNT, 32'h0);
    // quadrature on the second block: eight up, three down
    wr(B1 + A_CTL, 32'h1);
    repeat (8) src1.qStep(1'b1);
    repeat (3) src1.qStep(1'b0);
    rd(B1 + A_CNT, 32'h5);
    check({29'h0, isoLvl}, 32'h1);
    // both phases changing at once leave the count alone
    repeat (2) src1.jump();
    rd(B1 + A_CNT, 32'h5);
    // clear with both phases and reference high
    wr(B1 + A_CTL, 32'h11);
    src1.qStep(1'b1);
    src1.pulse(2, 1'b0);
    rd(B1 + A_CNT, 32'h0);
    repeat (2) src1.qStep(1'b1);
    rd(B1 + A_CNT, 32'h2);
    // clear on reference alone
    wr(B1 + A_CTL, 32'h51);
    src1.pulse(2, 1'b0);
    rd(B1 + A_CNT, 32'h0);
    // width analysis of a on rising edges while a also counts down
    wr(A_CTL, 32'h400);
    src0.square(0, 7, 13, 4);
    rd(A_HI, 32'h7 * qudp_pkg::PWM_STEP);
    rd(A_LO, 32'hd * qudp_pkg::PWM_STEP);
    rd(A_PER, 32'h14 * qudp_pkg::PWM_STEP);
    rd(A_CNT, 32'h0);
    rd(A_ST, 32'h1);
    wr(A_CMD, 32'h4);
    rd(A_ST, 32'h0);
    // width analysis of the reference on falling edges
    wr(A_CTL, 32'h700);
    src0.square(2, 5, 9, 4);
    rd(A_HI, 32'h5 * qudp_pkg::PWM_STEP);
    rd(A_LO, 32'h9 * qudp_pkg::PWM_STEP);
    rd(A_PER, 32'he * qudp_pkg::PWM_STEP);
    tally_and_finish();
  end
endmodule
